// ### pim_pkg.sv
// Package for the port and macrocell register block.
// Holds register offsets, port indices, reset values and sizes used by pim_regs.
`default_nettype none

package pim_pkg;

    localparam int NUM_PORTS = 6;
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;

    // Port indices in the per-port arrays: A, B, C, D, E, G.
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_G = 3'h5;

    // Port groups are laid out at BASE + 4 * port index, one word each.
    localparam logic [7:0] OFS_PIN_INPUT = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h20;
    localparam logic [7:0] OFS_DIRECTION = 8'h40;
    localparam logic [7:0] OFS_DRIVER_TYPE = 8'h60;
    localparam logic [7:0] OFS_OE_STATUS = 8'h80;
    localparam logic [7:0] OFS_INPUT_CELL = 8'hA0;
    localparam logic [7:0] OFS_CELL_BANK_A = 8'hA4;
    localparam logic [7:0] OFS_CELL_BANK_B = 8'hA8;
    localparam logic [7:0] OFS_CELL_LOCK_A = 8'hAC;
    localparam logic [7:0] OFS_CELL_LOCK_B = 8'hB0;

    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_DRIVER_TYPE = 8'h00;
    localparam logic [7:0] RST_CELL = 8'h00;
    localparam logic [7:0] RST_LOCK = 8'h00;

    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

`default_nettype wire

// ### pim_sync.sv
// Three-stage synchroniser with agreement filter for one port's pins.
// Assumes the inputs are asynchronous to clock.
`timescale 1ns/10ps
`default_nettype none

module pim_sync
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Data
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);

    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] out_q;
    logic [7:0] out_d;

    // A change counts once stages two and three agree.
    always_comb
    begin
        out_d = out_q;
        for (int i = 0; i < 8; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
            out_q <= 8'h00;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule // pim_sync

`default_nettype wire

// ### pim_regs.sv
// Port and macrocell register block, Avalon-MM slave with waitrequest.
// Assumes pins are resolved outside from out/oe (oe low means driving), and
// that the macrocell logic beside it supplies its own next-state and load pulses.
// Overview of operation
// R1: Input register read returns live pin levels, bit i is pin i.
// R2: Output latch holds host value and drives pin in output mode.
// R3: Direction 0 is input, 1 is output; input after reset.
// R4: Ports A, B, C, D, E, G each have eight-bit input, output, direction.
// R5: Ports A, B, E, G driver bit 0 push-pull, 1 open-drain.
// R6: Port C driver bit 0 CMOS, 1 slew-rate-controlled output.
// R7: Ports A, B, C enable-out reports driver state, 1 enabled, 0 tri-stated.
// R8: Read-only register returns the eight input macrocell states.
// R9: Host write to bank A or B loads the eight macrocell flip-flops.
// R10: Read of a bank returns current macrocell outputs, not last write.
// R11: Lock bit 1 blocks host loads of that macrocell; 0 allows.
// R12: Writes to read-only registers are ignored and change nothing.
`timescale 1ns/10ps
`default_nettype none

module pim_regs
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port pins, flattened port-major: port p bit i at index 8*p+i
    input wire logic [47:0] pin_in,
    output logic [47:0] pin_out,
    output logic [47:0] pin_oe_n,
    output logic [47:0] pin_slew_ctrl,
    // Macrocells
    input wire logic [7:0] input_cell_bits,
    input wire logic [7:0] cell_a_next,
    input wire logic [7:0] cell_b_next,
    input wire logic [7:0] cell_a_load,
    input wire logic [7:0] cell_b_load,
    output logic [7:0] output_cell_a_bits,
    output logic [7:0] output_cell_b_bits
);

    logic [5:0][7:0] latch_q;
    logic [5:0][7:0] latch_d;
    logic [5:0][7:0] dir_q;
    logic [5:0][7:0] dir_d;
    logic [5:0][7:0] drv_q;
    logic [5:0][7:0] drv_d;
    logic [5:0][7:0] pin_sync;
    logic [5:0][7:0] drive_en;
    logic [7:0] cell_a_q;
    logic [7:0] cell_a_d;
    logic [7:0] cell_b_q;
    logic [7:0] cell_b_d;
    logic [7:0] lock_a_q;
    logic [7:0] lock_a_d;
    logic [7:0] lock_b_q;
    logic [7:0] lock_b_d;
    logic [7:0] icell_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic ack_q;
    logic ack_d;
    logic wr_go;
    logic rd_go;
    logic [2:0] word_idx;
    logic [7:0] group_ofs;
    logic wr_lane;
    logic aligned;
    logic port_word;
    logic wr_port;
    logic wr_cell;

    // One wait cycle: read data is registered while waitrequest is high, and a
    // write lands only at the edge where the master samples waitrequest low.
    assign wr_go = avs_write && ack_q;
    assign rd_go = avs_read && !ack_q;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rdata_q;
    assign wr_lane = avs_byteenable[0];
    assign word_idx = avs_address[4:2];
    assign group_ofs = {avs_address[7:5], 5'h00};

    // Byte addresses off a word boundary decode to nothing, for reads and writes alike.
    assign aligned = avs_address[1:0] == 2'h0;
    assign port_word = aligned && word_idx < 3'h6;
    assign wr_port = wr_go && wr_lane && port_word;
    assign wr_cell = wr_go && wr_lane && aligned;

    // R4: Six eight-bit ports.
    genvar gp;
    generate
        for (gp = 0; gp < pim_pkg::NUM_PORTS; gp++)
        begin : g_port
            // R1: Pins synchronised before readback.
            pim_sync u_sync
            (
                .clock(clock),
                .rstn(rstn),
                .async_in(pin_in[8*gp +: 8]),
                .sync_out(pin_sync[gp])
            );
            // R3: Direction 1 drives.
            // R5: Open-drain drives only a low level.
            assign drive_en[gp] = (gp == pim_pkg::PORT_C || gp == pim_pkg::PORT_D)
                ? dir_q[gp] : (dir_q[gp] & ~(drv_q[gp] & latch_q[gp]));
            // R2: Latched bit goes out on the pin.
            assign pin_out[8*gp +: 8] = latch_q[gp];
            assign pin_oe_n[8*gp +: 8] = ~drive_en[gp];
            // R6: Slew-rate mode only on port C.
            assign pin_slew_ctrl[8*gp +: 8] = (gp == pim_pkg::PORT_C)
                ? (drv_q[gp] & dir_q[gp]) : 8'h00;
        end
    endgenerate

    // R2: Host writes to the output latches, direction and driver type.
    always_comb
    begin
        latch_d = latch_q;
        dir_d = dir_q;
        drv_d = drv_q;
        if (wr_port)
        begin
            unique case (group_ofs)
                pim_pkg::OFS_OUTPUT_LATCH:
                begin
                    latch_d[word_idx] = avs_writedata[7:0];
                end
                // R3: Direction bits, 1 drives the pin.
                pim_pkg::OFS_DIRECTION:
                begin
                    dir_d[word_idx] = avs_writedata[7:0];
                end
                // R5: Driver type held for every port except D, which has no driver control.
                pim_pkg::OFS_DRIVER_TYPE:
                begin
                    if (word_idx != pim_pkg::PORT_D)
                    begin
                        drv_d[word_idx] = avs_writedata[7:0];
                    end
                end
                // R12: Read-only and unmapped offsets leave every register alone.
                default:
                begin
                end
            endcase
        end
    end

    // R3: Every pin an input after reset.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            latch_q <= {6{pim_pkg::RST_OUTPUT_LATCH}};
            dir_q <= {6{pim_pkg::RST_DIRECTION}};
            drv_q <= {6{pim_pkg::RST_DRIVER_TYPE}};
        end
        else
        begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            drv_q <= drv_d;
        end
    end

    // Macrocell flip-flops and their lock masks.
    always_comb
    begin
        lock_a_d = lock_a_q;
        lock_b_d = lock_b_q;
        // The macrocell logic loads first; an unlocked host write in the same cycle wins.
        for (int i = 0; i < 8; i++)
        begin
            cell_a_d[i] = cell_a_load[i] ? cell_a_next[i] : cell_a_q[i];
            cell_b_d[i] = cell_b_load[i] ? cell_b_next[i] : cell_b_q[i];
        end
        if (wr_cell)
        begin
            unique case (avs_address)
                // R9: Host load of bank flip-flops.
                // R11: Locked bits keep what the macrocell logic gives them.
                pim_pkg::OFS_CELL_BANK_A:
                begin
                    cell_a_d = (avs_writedata[7:0] & ~lock_a_q) | (cell_a_d & lock_a_q);
                end
                pim_pkg::OFS_CELL_BANK_B:
                begin
                    cell_b_d = (avs_writedata[7:0] & ~lock_b_q) | (cell_b_d & lock_b_q);
                end
                pim_pkg::OFS_CELL_LOCK_A:
                begin
                    lock_a_d = avs_writedata[7:0];
                end
                pim_pkg::OFS_CELL_LOCK_B:
                begin
                    lock_b_d = avs_writedata[7:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cell_a_q <= pim_pkg::RST_CELL;
            cell_b_q <= pim_pkg::RST_CELL;
            lock_a_q <= pim_pkg::RST_LOCK;
            lock_b_q <= pim_pkg::RST_LOCK;
        end
        else
        begin
            cell_a_q <= cell_a_d;
            cell_b_q <= cell_b_d;
            lock_a_q <= lock_a_d;
            lock_b_q <= lock_b_d;
        end
    end

    // Read mux and handshake. The read data is captured while waitrequest is
    // high, so it already stands at the edge where the master takes it.
    always_comb
    begin
        ack_d = (avs_read || avs_write) && !ack_q;
        rdata_d = rdata_q;
        if (rd_go)
        begin
            rdata_d = pim_pkg::UNMAPPED_READ;
            if (port_word)
            begin
                unique case (group_ofs)
                    // R1: Live pin levels.
                    pim_pkg::OFS_PIN_INPUT:
                    begin
                        rdata_d[7:0] = pin_sync[word_idx];
                    end
                    pim_pkg::OFS_OUTPUT_LATCH:
                    begin
                        rdata_d[7:0] = latch_q[word_idx];
                    end
                    pim_pkg::OFS_DIRECTION:
                    begin
                        rdata_d[7:0] = dir_q[word_idx];
                    end
                    pim_pkg::OFS_DRIVER_TYPE:
                    begin
                        rdata_d[7:0] = drv_q[word_idx];
                    end
                    // R7: Enable-out only for ports A, B, C.
                    pim_pkg::OFS_OE_STATUS:
                    begin
                        if (word_idx <= pim_pkg::PORT_C)
                        begin
                            rdata_d[7:0] = drive_en[word_idx];
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            unique case (avs_address)
                // R8: Input macrocell states.
                pim_pkg::OFS_INPUT_CELL:
                begin
                    rdata_d[7:0] = icell_q;
                end
                // R10: Current flip-flop outputs, not the last value written.
                pim_pkg::OFS_CELL_BANK_A:
                begin
                    rdata_d[7:0] = cell_a_q;
                end
                pim_pkg::OFS_CELL_BANK_B:
                begin
                    rdata_d[7:0] = cell_b_q;
                end
                pim_pkg::OFS_CELL_LOCK_A:
                begin
                    rdata_d[7:0] = lock_a_q;
                end
                pim_pkg::OFS_CELL_LOCK_B:
                begin
                    rdata_d[7:0] = lock_b_q;
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            icell_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
        end
        else
        begin
            icell_q <= input_cell_bits;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    assign output_cell_a_bits = cell_a_q;
    assign output_cell_b_bits = cell_b_q;

endmodule // pim_regs

`default_nettype wire

// ### pim_regs_monitor.sv
// Checker for the port and macrocell register block.
// Assumes it is bound to pim_regs and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module pim_regs_monitor
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins and macrocells
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe_n,
    input wire logic [47:0] pin_slew_ctrl,
    input wire logic [7:0] cell_a_load,
    input wire logic [7:0] output_cell_a_bits
);
    logic take;
    logic [7:0] lock_a_d;
    logic [7:0] lock_a_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // A write lands on the edge where waitrequest is seen low; only byte lane 0 counts.
    assign take = avs_write & !avs_waitrequest & avs_byteenable[0];

    always_comb
    begin
        lock_a_d = lock_a_q;
        if (take && avs_address == 8'hAC)
            lock_a_d = avs_writedata[7:0];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            lock_a_q <= 8'h00;
        else
            lock_a_q <= lock_a_d;
    end

    chk_idle_ready: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    chk_first_wait: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
        else $error("request answered without a wait state");
    chk_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    chk_reset_pins: assert property ($rose(rstn) |-> &pin_oe_n && pin_out == 48'h0)
        else $error("pins not inputs after reset");
    chk_latch_hold: assert property (!(avs_write && !avs_waitrequest) |=> $stable(pin_out))
        else $error("output latch changed without a write");
    chk_cell_hold: assert property (!(avs_write && !avs_waitrequest) && cell_a_load == 8'h00
        |=> $stable(output_cell_a_bits))
        else $error("bank A changed without a load");
    chk_bank_load: assert property (take && avs_address == 8'hA4 && cell_a_load == 8'h00
        |=> output_cell_a_bits == (($past(output_cell_a_bits) & lock_a_q)
        | ($past(avs_writedata[7:0]) & ~lock_a_q)))
        else $error("bank A write did not respect the lock");
    chk_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_slew_port: assert property (pin_slew_ctrl[47:24] == 24'h0 && pin_slew_ctrl[15:0] == 16'h0
        && (pin_slew_ctrl[23:16] & pin_oe_n[23:16]) == 8'h00)
        else $error("slew mode outside driven port C pins");
endmodule // pim_regs_monitor

bind pim_regs pim_regs_monitor u_mon
(
    .clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .pin_out, .pin_oe_n, .pin_slew_ctrl, .cell_a_load,
    .output_cell_a_bits
);

`default_nettype wire

// ### pim_board.sv
// Board model facing the port pins.
// Assumes an undriven pin settles to the board level that the bench sets.
`timescale 1ns/10ps
`default_nettype none

module pim_board
(
    // From the block
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe_n,
    // Board level seen on released pins
    input wire logic [47:0] ext,
    // To the block
    output logic [47:0] pin_in
);
    assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule // pim_board

`default_nettype wire

// ### test_pim_regs.sv
// Self-checking bench for the port and macrocell register block.
// Assumes the board model resolves pins and the bound checker watches the ports.
`timescale 1ns/10ps
`default_nettype none

module test_pim_regs;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [47:0] pin_in, pin_out, pin_oe_n, pin_slew_ctrl;
    logic [47:0] ext = 48'h0;
    logic [7:0] input_cell_bits = 8'h00;
    logic [7:0] cnx = 8'h00;
    logic [7:0] cld = 8'h00;
    logic [7:0] a, d, o, output_cell_a_bits, output_cell_b_bits;
    int miscompares = 0;
    int n_compared = 0;
    logic [31:0] expq[$];

    pim_regs dut
    (
        .clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out,
        .pin_oe_n, .pin_slew_ctrl, .input_cell_bits, .cell_a_next(cnx),
        .cell_b_next(cnx), .cell_a_load(cld), .cell_b_load(cld),
        .output_cell_a_bits, .output_cell_b_bits
    );

    pim_board board
    (
        .pin_out, .pin_oe_n, .ext, .pin_in
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task results;
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Holds the request until waitrequest is seen low, then idles one cycle.
    task automatic xfer(input logic [7:0] adr, input logic w, input logic [7:0] dat);
        avs_address <= adr;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, dat};
        @(posedge clock iff !avs_waitrequest);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_exp(input logic [7:0] adr, input logic [7:0] e);
        expq.push_back({24'h0, e});
        xfer(adr, 1'b0, 8'h00);
    endtask

    always #20 clock = ~clock;

    always @(posedge clock)
    begin
        if (avs_read && !avs_waitrequest)
            check(avs_readdata, expq.pop_front());
    end

    initial
    begin
        #400000;
        miscompares++;
        results;
    end

    initial
    begin
        void'($urandom(32'hB6DB));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        ext <= 48'({$urandom(), $urandom()});
        @(posedge clock);
        for (int p = 0; p < 6; p++)
        begin
            a = 8'(4 * p);
            d = 8'($urandom());
            o = ext[8 * p +: 8];
            rd_exp(8'h40 + a, 8'h00);
            rd_exp(8'h60 + a, 8'h00);
            rd_exp(8'h80 + a, 8'h00);
            rd_exp(a, o);
            xfer(8'h20 + a, 1'b1, d);
            xfer(8'h40 + a, 1'b1, 8'hFF);
            xfer(a, 1'b1, ~d);
            repeat (5) @(posedge clock);
            rd_exp(a, d);
            rd_exp(8'h40 + a, 8'hFF);
            rd_exp(8'h20 + a, d);
            rd_exp(8'h80 + a, p < 3 ? 8'hFF : 8'h00);
            xfer(8'h60 + a, 1'b1, 8'hFF);
            repeat (5) @(posedge clock);
            rd_exp(8'h60 + a, p == 3 ? 8'h00 : 8'hFF);
            rd_exp(a, p == 2 || p == 3 ? d : d & o);
            rd_exp(8'h80 + a, p < 2 ? ~d : p == 2 ? 8'hFF : 8'h00);
            check({24'h0, pin_slew_ctrl[8 * p +: 8]}, p == 2 ? 32'hFF : 32'h0);
        end
        input_cell_bits <= 8'($urandom());
        xfer(8'hA0, 1'b1, 8'h5A);
        rd_exp(8'hA0, input_cell_bits);
        rd_exp(8'hFC, 8'h00);
        // host loads, locks and cell logic loads
        for (int b = 0; b < 2; b++)
        begin
            a = 8'hA4 + 8'(4 * b);
            d = 8'($urandom());
            xfer(a, 1'b1, d);
            rd_exp(a, d);
            xfer(a + 8'h08, 1'b1, 8'hF0);
            rd_exp(a + 8'h08, 8'hF0);
            xfer(a, 1'b1, ~d);
            rd_exp(a, {d[7:4], ~d[3:0]});
            cnx <= ~d;
            cld <= 8'hFF;
            @(posedge clock);
            cld <= 8'h00;
            rd_exp(a, ~d);
            check({24'h0, b == 0 ? output_cell_a_bits : output_cell_b_bits}, {24'h0, ~d});
        end
        results;
    end
endmodule // test_pim_regs

`default_nettype wire
